// File: logic/ftr_regs.sv
// Operation
// - rw threshold register, peer and collision fields
// - threshold register resets to 0x33
// - peer code maps monotonic 75 to 800 mvpp
// - collision msb picks fine 25-250 range
// - read-only timing readout, ratio high nibble
// - timing class slow through fast decode
// - bit 7 selects calibrated or external voltage
// - external code bits, register resets zero
// - supply measure source select, 110/111 reserved
// - external code shares regulator display encoding
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ftr_regs #(
   parameter int DATA_W = 8
) (
   input  wire logic                core_clk_in,
   input  wire logic                rst_in,
   input  wire ftr_pkg::ftr_req_s   req_in,
   output logic [7:0]               rd_data_out,
   input  wire ftr_pkg::ftr_drv_s   drv_status_in,
   input  wire logic [3:0]          cal_reg_code_in,
   output logic [2:0]               peer_off_level_out,
   output logic [3:0]               collision_off_level_out,
   output logic [9:0]               peer_off_mvpp_out,
   output logic [9:0]               collision_off_mvpp_out,
   output logic                     collision_fine_range_out,
   output logic [3:0]               transient_ratio_out,
   output var ftr_pkg::ftr_speed_e  driver_speed_class_out,
   output logic                     reg_from_ext_out,
   output logic [3:0]               reg_code_out,
   output logic [2:0]               measured_supply_select_out,
   output var ftr_pkg::ftr_supply_e measured_supply_source_out,
   output logic                     measured_supply_valid_out
);
   import ftr_pkg::*;

   // the byte layout is fixed by the register map
   if (DATA_W != 8) begin : g_bad_width
      $error("ftr_regs: DATA_W must be 8");
   end

   // coarse ladder shared by peer and collision codes
   function automatic logic [9:0] coarse_mvpp(input logic [2:0] code);
      logic [9:0] mv;
      mv = 10'h000;
      case (code)
         3'h0:    mv = 10'd75;
         3'h1:    mv = 10'd105;
         3'h2:    mv = 10'd150;
         3'h3:    mv = 10'd205;
         3'h4:    mv = 10'd290;
         3'h5:    mv = 10'd400;
         3'h6:    mv = 10'd560;
         default: mv = 10'd800;
      endcase
      return mv;
   endfunction : coarse_mvpp

   // fine ladder for collision codes with the top bit set
   function automatic logic [9:0] fine_mvpp(input logic [2:0] code);
      logic [9:0] mv;
      mv = 10'h000;
      case (code)
         3'h0:    mv = 10'd25;
         3'h1:    mv = 10'd33;
         3'h2:    mv = 10'd47;
         3'h3:    mv = 10'd64;
         3'h4:    mv = 10'd90;
         3'h5:    mv = 10'd125;
         3'h6:    mv = 10'd175;
         default: mv = 10'd250;
      endcase
      return mv;
   endfunction : fine_mvpp

   // registers
   logic [7:0]  off_thresh_ff;
   logic [7:0]  reg_ctrl_ff;
   logic [7:0]  rd_data_ff;
   ftr_drv_s    drv_meta_ff;
   ftr_drv_s    drv_sync_ff;
   logic [3:0]  cal_meta_ff;
   logic [3:0]  cal_sync_ff;
   logic [9:0]  peer_mv_ff;
   logic [9:0]  coll_mv_ff;
   logic [3:0]  reg_code_ff;
   ftr_speed_e  speed_ff;
   ftr_supply_e supply_ff;
   logic        supply_ok_ff;

   // next values
   logic [7:0]  nxt_off_thresh;
   logic [7:0]  nxt_reg_ctrl;
   logic [7:0]  nxt_rd_data;
   logic [9:0]  nxt_peer_mv;
   logic [9:0]  nxt_coll_mv;
   logic [3:0]  nxt_reg_code;
   ftr_speed_e  nxt_speed;
   ftr_supply_e nxt_supply;
   logic        nxt_supply_ok;

   // address decode
   wire         hit_thresh;
   wire         hit_timing;
   wire         hit_regctl;
   wire         wr_thresh;
   wire         wr_regctl;
   wire [7:0]   timing_view;

   assign hit_thresh = !req_in.space_b && (req_in.addr == ADDR_OFF_THRESH);
   assign hit_timing = req_in.space_b && (req_in.addr == ADDR_DRV_TIMING);
   assign hit_regctl = !req_in.space_b && (req_in.addr == ADDR_REG_CTRL);
   assign wr_thresh  = req_in.wr && hit_thresh;
   assign wr_regctl  = req_in.wr && hit_regctl;

   // readout image, bit 3 forced to zero
   assign timing_view = {drv_sync_ff.ratio, 1'b0, drv_sync_ff.speed};

   // register write paths; timing readout ignores writes
   assign nxt_off_thresh = wr_thresh ? (req_in.wdata & OFF_THRESH_WMASK)
                                     : off_thresh_ff;
   assign nxt_reg_ctrl   = wr_regctl ? req_in.wdata : reg_ctrl_ff;

   // read mux, unmapped addresses read zero
   assign nxt_rd_data = !req_in.rd ? RD_IDLE :
                        hit_thresh ? off_thresh_ff :
                        hit_timing ? timing_view :
                        hit_regctl ? reg_ctrl_ff : RD_IDLE;

   // threshold decode to mvpp
   assign nxt_peer_mv = coarse_mvpp(off_thresh_ff[PEER_MSB:PEER_LSB]);
   assign nxt_coll_mv = off_thresh_ff[COLL_MSB]
                      ? fine_mvpp(off_thresh_ff[COLL_MSB-1:COLL_LSB])
                      : coarse_mvpp(off_thresh_ff[COLL_MSB-1:COLL_LSB]);

   // regulated voltage source; both codes use the display encoding
   assign nxt_reg_code = reg_ctrl_ff[REGS_BIT]
                       ? reg_ctrl_ff[REGE_MSB:REGE_LSB]
                       : cal_sync_ff;

   // driver timing class decode
   always_comb begin
      nxt_speed = SPD_FAST;
      if (!drv_sync_ff.speed[2]) begin
         case (drv_sync_ff.speed[1:0])
            2'h0:    nxt_speed = SPD_SLOW;
            2'h1:    nxt_speed = SPD_MED_SLOW;
            2'h2:    nxt_speed = SPD_NOMINAL;
            default: nxt_speed = SPD_MED_FAST;
         endcase
      end
   end

   // supply measurement source decode
   always_comb begin
      nxt_supply    = SUP_RESERVED;
      nxt_supply_ok = 1'b1;
      case (reg_ctrl_ff[MPS_MSB:MPS_LSB])
         3'h0:    nxt_supply = SUP_MAIN;
         3'h1:    nxt_supply = SUP_ANALOG;
         3'h2:    nxt_supply = SUP_DIGITAL;
         3'h3:    nxt_supply = SUP_RF_DRIVER;
         3'h4:    nxt_supply = SUP_AM_REF;
         3'h5:    nxt_supply = SUP_TX;
         default: nxt_supply_ok = 1'b0;
      endcase
   end

   // two-stage synchronisers for the analog status
   always_ff @(posedge core_clk_in) begin
      drv_meta_ff <= drv_status_in;
      drv_sync_ff <= drv_meta_ff;
      cal_meta_ff <= cal_reg_code_in;
      cal_sync_ff <= cal_meta_ff;
   end

   // software registers
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         off_thresh_ff <= OFF_THRESH_RST;
         reg_ctrl_ff   <= REG_CTRL_RST;
         rd_data_ff    <= RD_IDLE;
      end else begin
         off_thresh_ff <= nxt_off_thresh;
         reg_ctrl_ff   <= nxt_reg_ctrl;
         rd_data_ff    <= nxt_rd_data;
      end
   end

   // decoded outputs
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         peer_mv_ff   <= 10'h000;
         coll_mv_ff   <= 10'h000;
         reg_code_ff  <= 4'h0;
         speed_ff     <= SPD_SLOW;
         supply_ff    <= SUP_MAIN;
         supply_ok_ff <= 1'b0;
      end else begin
         peer_mv_ff   <= nxt_peer_mv;
         coll_mv_ff   <= nxt_coll_mv;
         reg_code_ff  <= nxt_reg_code;
         speed_ff     <= nxt_speed;
         supply_ff    <= nxt_supply;
         supply_ok_ff <= nxt_supply_ok;
      end
   end

   // output drive
   assign rd_data_out                = rd_data_ff;
   assign peer_off_level_out         = off_thresh_ff[PEER_MSB:PEER_LSB];
   assign collision_off_level_out    = off_thresh_ff[COLL_MSB:COLL_LSB];
   assign collision_fine_range_out   = off_thresh_ff[COLL_MSB];
   assign peer_off_mvpp_out          = peer_mv_ff;
   assign collision_off_mvpp_out     = coll_mv_ff;
   assign transient_ratio_out        = drv_sync_ff.ratio;
   assign driver_speed_class_out     = speed_ff;
   assign reg_from_ext_out           = reg_ctrl_ff[REGS_BIT];
   assign reg_code_out               = reg_code_ff;
   assign measured_supply_select_out = reg_ctrl_ff[MPS_MSB:MPS_LSB];
   assign measured_supply_source_out = supply_ff;
   assign measured_supply_valid_out  = supply_ok_ff;

endmodule : ftr_regs
`default_nettype wire

// File: logic/ftr_pkg.sv
package ftr_pkg;

   // register addresses inside each space
   localparam logic [5:0] ADDR_OFF_THRESH  = 6'h2b; // space a
   localparam logic [5:0] ADDR_DRV_TIMING  = 6'h2b; // space b
   localparam logic [5:0] ADDR_REG_CTRL    = 6'h2c; // space a

   // reset values
   localparam logic [7:0] OFF_THRESH_RST   = 8'h33;
   localparam logic [7:0] REG_CTRL_RST     = 8'h00;
   localparam logic [7:0] RD_IDLE          = 8'h00;

   // field positions of the threshold register
   localparam int         PEER_MSB         = 6;
   localparam int         PEER_LSB         = 4;
   localparam int         COLL_MSB         = 3;
   localparam int         COLL_LSB         = 0;

   // field positions of the timing readout
   localparam int         RATIO_MSB        = 7;
   localparam int         RATIO_LSB        = 4;
   localparam int         CLASS_MSB        = 2;
   localparam int         CLASS_LSB        = 0;

   // field positions of the regulator control register
   localparam int         REGS_BIT         = 7;
   localparam int         REGE_MSB         = 6;
   localparam int         REGE_LSB         = 3;
   localparam int         MPS_MSB          = 2;
   localparam int         MPS_LSB          = 0;

   // writable bits, reserved positions stay zero
   localparam logic [7:0] OFF_THRESH_WMASK = 8'h7f;

   // software access request
   typedef struct packed {
      logic       space_b;
      logic [5:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ftr_req_s;

   // driver timing status coming from the analog driver
   typedef struct packed {
      logic [3:0] ratio;
      logic [2:0] speed;
   } ftr_drv_s;

   // driver timing class
   typedef enum logic [2:0] {
      SPD_SLOW,
      SPD_MED_SLOW,
      SPD_NOMINAL,
      SPD_MED_FAST,
      SPD_FAST
   } ftr_speed_e;

   // supply measurement source
   typedef enum logic [2:0] {
      SUP_MAIN,
      SUP_ANALOG,
      SUP_DIGITAL,
      SUP_RF_DRIVER,
      SUP_AM_REF,
      SUP_TX,
      SUP_RESERVED
   } ftr_supply_e;

endpackage : ftr_pkg

// File: verif/ftr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ftr_regs_chk
   import ftr_pkg::*;
(
   input wire logic              core_clk_in,
   input wire logic              rst_in,
   input wire ftr_pkg::ftr_req_s req_in,
   input wire logic [7:0]        rd_data_out,
   input wire logic [2:0]        peer_off_level_out,
   input wire logic [3:0]        collision_off_level_out,
   input wire logic              collision_fine_range_out,
   input wire logic [9:0]        peer_off_mvpp_out,
   input wire logic [9:0]        collision_off_mvpp_out,
   input wire logic              reg_from_ext_out,
   input wire logic [3:0]        reg_code_out,
   input wire logic [2:0]        measured_supply_select_out,
   input wire logic              measured_supply_valid_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   // decoded write strobes
   wire thr_wr = req_in.wr && !req_in.space_b && req_in.addr == 6'h2b;
   wire ctl_wr = req_in.wr && !req_in.space_b && req_in.addr == 6'h2c;
   rd_idle_a: assert property (!$past(req_in.rd) |-> rd_data_out == 8'h00) else $error("read data not idle");
   thr_write_a: assert property (thr_wr |=> {peer_off_level_out, collision_off_level_out} == $past(req_in.wdata[6:0]))
      else $error("threshold write lost");
   fine_range_a: assert property (collision_fine_range_out == collision_off_level_out[3]) else $error("range flag");
   ctl_write_a: assert property (ctl_wr |=> {reg_from_ext_out, measured_supply_select_out} ==
      {$past(req_in.wdata[7]), $past(req_in.wdata[2:0])}) else $error("control write lost");
   ext_code_a: assert property ((ctl_wr && req_in.wdata[7]) ##1 !req_in.wr |=> reg_code_out == $past(req_in.wdata[6:3], 2))
      else $error("external code not used");
   supply_valid_a: assert property (!$past(rst_in) |-> measured_supply_valid_out == ($past(measured_supply_select_out) < 3'h6))
      else $error("supply valid wrong");
   peer_top_a: assert property (!$past(rst_in) && $past(peer_off_level_out) == 3'h7 |-> peer_off_mvpp_out == 10'h320)
      else $error("peer top level");
   fine_low_a: assert property (!$past(rst_in) && $past(collision_off_level_out) == 4'h8 |-> collision_off_mvpp_out == 10'h019)
      else $error("fine low level");
endmodule : ftr_regs_chk
bind ftr_regs ftr_regs_chk u_chk (.*);
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ftr_pkg::*;
   logic        core_clk_in, rst_in, collision_fine_range_out, reg_from_ext_out, measured_supply_valid_out;
   ftr_req_s    req_in;
   ftr_drv_s    drv_status_in;
   logic [3:0]  cal_reg_code_in, collision_off_level_out, transient_ratio_out, reg_code_out;
   logic [7:0]  rd_data_out;
   logic [2:0]  peer_off_level_out, measured_supply_select_out;
   logic [9:0]  peer_off_mvpp_out, collision_off_mvpp_out;
   ftr_speed_e  driver_speed_class_out;
   ftr_supply_e measured_supply_source_out;
   int          err_total, samples_checked;
   logic [9:0]  pmv [8] = '{10'h04b, 10'h069, 10'h096, 10'h0cd, 10'h122, 10'h190, 10'h230, 10'h320};
   logic [9:0]  fmv [8] = '{10'h019, 10'h021, 10'h02f, 10'h040, 10'h05a, 10'h07d, 10'h0af, 10'h0fa};
   logic [4:0]  i;
   logic [7:0]  d;
   ftr_regs #(.DATA_W(8)) uut (.*);
   // clock
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   // compare and count
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one-cycle write strobe
   task automatic wr(input logic b, input logic [5:0] a, input logic [7:0] v);
      @(posedge core_clk_in) req_in <= '{b, a, v, 1'b1, 1'b0};
      @(posedge core_clk_in) req_in <= '0;
   endtask : wr
   // one-cycle read strobe, data checked in the next cycle
   task automatic rd(input logic b, input logic [5:0] a, input logic [7:0] e);
      @(posedge core_clk_in) req_in <= '{b, a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk_in) req_in <= '0;
      #1 chk("read data", {2'h0, e}, {2'h0, rd_data_out});
   endtask : rd
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   // watchdog
   initial begin
      repeat (3000) @(posedge core_clk_in);
      err_total++;
      give_verdict();
   end
   // test sequence
   initial begin
      rst_in = 1'b1;
      req_in = '0;
      drv_status_in = '{4'h9, 3'h6};
      cal_reg_code_in = 4'h5;
      repeat (6) @(posedge core_clk_in);
      rst_in <= 1'b0;
      rd(1'b0, 6'h2b, 8'h33);
      rd(1'b0, 6'h2c, 8'h00);
      rd(1'b0, 6'h2d, 8'h00);
      $display("reset values done");
      for (i = 0; i < 16; i++) begin
         wr(1'b0, 6'h2b, {1'b1, i[2:0], i[3:0]});
         rd(1'b0, 6'h2b, {1'b0, i[2:0], i[3:0]});
         chk("peer mvpp", pmv[i[2:0]], peer_off_mvpp_out);
         chk("coll mvpp", i[3] ? fmv[i[2:0]] : pmv[i[2:0]], collision_off_mvpp_out);
         chk("fine flag", {9'h0, i[3]}, {9'h0, collision_fine_range_out});
      end
      wr(1'b1, 6'h2b, 8'h00);
      rd(1'b0, 6'h2b, 8'h7f);
      $display("thresholds done");
      for (i = 0; i < 8; i++) begin
         @(posedge core_clk_in) drv_status_in <= '{i[3:0] ^ 4'hc, i[2:0]};
         d = {i[0], i[3:0] ^ 4'ha, i[2:0]};
         wr(1'b0, 6'h2c, d);
         rd(1'b0, 6'h2c, d);
         rd(1'b1, 6'h2b, {i[3:0] ^ 4'hc, 1'b0, i[2:0]});
         chk("speed class", i[2] ? 10'h004 : {7'h0, i[2:0]}, {7'h0, driver_speed_class_out});
         chk("ratio", {6'h0, i[3:0] ^ 4'hc}, {6'h0, transient_ratio_out});
         chk("reg code", {6'h0, i[0] ? i[3:0] ^ 4'ha : 4'h5}, {6'h0, reg_code_out});
         chk("supply src", i > 5 ? 10'h006 : {7'h0, i[2:0]}, {7'h0, measured_supply_source_out});
         chk("supply ok", {9'h0, i < 6}, {9'h0, measured_supply_valid_out});
      end
      $display("regulator and readout done");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
